// *** lecc_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing figures for the link
//          error address and clock control register bank.
// Assumes: Included by its bare name from the package and the design modules.
// Notes:   Contract
// Contract
// - Capture 16-bit address of first transaction raising timeout or error flag
// - After capture, lock the field; later errors ignored until software writes
// - Any host or controller write to the error address clears captured address to zero and re-arms
// - Lock engages even for address zero; lock tracked apart from value
// - Clock control register resets to all zeros on system reset
// - Two-bit clock select in D1:D0 is read/write; other bits read zero
// - Select 0,1,2,3 gives link clock 64, 32, 16, 8 MHz
// - Select writes go to a buffer, copied only while link clock stopped
`ifndef LECC_CFG_SVH
`define LECC_CFG_SVH

// Host configuration indexes (byte wide)
`define LECC_HOST_IDX_CLK 8'hf8
`define LECC_HOST_IDX_ERR_LO 8'hf4
`define LECC_HOST_IDX_ERR_HI 8'hf5

// Controller peripheral bus offsets (word wide)
`define LECC_EC_OFS_CLK 12'h3f8
`define LECC_EC_OFS_ERR 12'h3f4

// Field layout
`define LECC_CLK_SEL_LSB 0
`define LECC_CLK_SEL_W 2
`define LECC_ERR_ADDR_W 16

// Reset values
`define LECC_CLK_CTRL_RST 32'h0000_0000
`define LECC_CLK_SEL_RST 2'h0
`define LECC_ERR_ADDR_RST 16'h0000

// Link clock rates in MHz per select code
`define LECC_MHZ_SEL0 7'h40
`define LECC_MHZ_SEL1 7'h20
`define LECC_MHZ_SEL2 7'h10
`define LECC_MHZ_SEL3 7'h08

`endif

// *** lecc_pkg.sv ***
// Purpose: Types shared by the link error address and clock control bank.
// Assumes: lecc_cfg.svh is included, but the widths and select codes here are written as literals.
// Notes:   Requests carry a one-cycle valid.
`include "lecc_cfg.svh"
package lecc_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
    logic [7:0] wdata;
  } lecc_host_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] offset;
    logic [31:0] wdata;
  } lecc_ec_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } lecc_err_evt_t;

  typedef enum logic [1:0] {
    LECC_CLK_64 = 2'h0,
    LECC_CLK_32 = 2'h1,
    LECC_CLK_16 = 2'h2,
    LECC_CLK_8  = 2'h3
  } lecc_clk_sel_t;

endpackage

// *** lecc_err_capture.sv ***
// Purpose: First-error address capture with lock and clear-on-write.
// Assumes: Events and clear come from logic on mclk.
// Notes:   Clear wins over a same-cycle event; that event is held one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "lecc_cfg.svh"
module lecc_err_capture #(
  parameter int ADDR_W = `LECC_ERR_ADDR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire lecc_pkg::lecc_err_evt_t evt,
  input wire logic clear,
  output logic [ADDR_W-1:0] addr_q,
  output logic locked_q
);
  import lecc_pkg::*;

  logic pend_q;
  logic [ADDR_W-1:0] pend_addr_q;

  // Event parked behind a clearing write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_addr_q <= '0;
    end else begin
      pend_q <= clear && evt.valid;
      pend_addr_q <= evt.addr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      locked_q <= 1'b0;
    end else if (clear) begin
      addr_q <= '0;
      locked_q <= 1'b0;
    end else if (!locked_q && pend_q) begin
      addr_q <= pend_addr_q;
      locked_q <= 1'b1;
    end else if (!locked_q && evt.valid) begin
      addr_q <= evt.addr[ADDR_W-1:0];
      locked_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** lecc_regs.sv ***
// Purpose: Register bank holding the captured error address and the link clock select.
// Assumes: Host config and controller bus requests are one-cycle pulses on mclk;
//          link_clk_run and error events come from logic on mclk.
// Notes:   Read data and acks appear one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
`include "lecc_cfg.svh"
module lecc_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire lecc_pkg::lecc_host_req_t host_req,
  output logic host_ack_q,
  output logic [7:0] host_rdata_q,
  input wire lecc_pkg::lecc_ec_req_t ec_req,
  output logic ec_ack_q,
  output logic [31:0] ec_rdata_q,
  input wire lecc_pkg::lecc_err_evt_t err_evt,
  input wire logic link_clk_run,
  output lecc_pkg::lecc_clk_sel_t clk_sel_q,
  output logic [6:0] link_clk_mhz_q,
  output logic err_locked_q
);
  import lecc_pkg::*;

  logic rst_meta_q;
  logic rst_n;
  logic host_wr_clk;
  logic ec_wr_clk;
  logic host_wr_err;
  logic ec_wr_err;
  logic err_clear;
  logic [`LECC_CLK_SEL_W-1:0] hold_q;
  logic [`LECC_ERR_ADDR_W-1:0] err_addr;
  logic err_locked;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign host_wr_clk = host_req.valid && host_req.write && host_req.index == `LECC_HOST_IDX_CLK;
  assign ec_wr_clk = ec_req.valid && ec_req.write && ec_req.offset == `LECC_EC_OFS_CLK;
  assign host_wr_err = host_req.valid && host_req.write &&
                       (host_req.index == `LECC_HOST_IDX_ERR_LO ||
                        host_req.index == `LECC_HOST_IDX_ERR_HI);
  assign ec_wr_err = ec_req.valid && ec_req.write && ec_req.offset == `LECC_EC_OFS_ERR;
  assign err_clear = host_wr_err || ec_wr_err;

  lecc_err_capture #(
    .ADDR_W(`LECC_ERR_ADDR_W)
  ) u_capture (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt(err_evt),
    .clear(err_clear),
    .addr_q(err_addr),
    .locked_q(err_locked)
  );

  // Holding buffer; controller wins a same-cycle collision
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= `LECC_CLK_SEL_RST;
    end else if (ec_wr_clk) begin
      hold_q <= ec_req.wdata[`LECC_CLK_SEL_LSB +: `LECC_CLK_SEL_W];
    end else if (host_wr_clk) begin
      hold_q <= host_req.wdata[`LECC_CLK_SEL_LSB +: `LECC_CLK_SEL_W];
    end
  end

  // Active setting follows the buffer only while link clock stopped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= LECC_CLK_64;
    end else if (!link_clk_run) begin
      clk_sel_q <= lecc_clk_sel_t'(hold_q);
    end
  end

  // Link clock rate from the active setting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_mhz_q <= `LECC_MHZ_SEL0;
    end else begin
      unique case (clk_sel_q)
        LECC_CLK_64: link_clk_mhz_q <= `LECC_MHZ_SEL0;
        LECC_CLK_32: link_clk_mhz_q <= `LECC_MHZ_SEL1;
        LECC_CLK_16: link_clk_mhz_q <= `LECC_MHZ_SEL2;
        LECC_CLK_8: link_clk_mhz_q <= `LECC_MHZ_SEL3;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_locked_q <= 1'b0;
    end else begin
      err_locked_q <= err_locked;
    end
  end

  // Host reads; unmapped indexes read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_ack_q <= 1'b0;
      host_rdata_q <= 8'h00;
    end else begin
      host_ack_q <= host_req.valid;
      if (host_req.valid && !host_req.write) begin
        unique case (host_req.index)
          `LECC_HOST_IDX_CLK: host_rdata_q <= {6'h00, clk_sel_q};
          `LECC_HOST_IDX_ERR_LO: host_rdata_q <= err_addr[7:0];
          `LECC_HOST_IDX_ERR_HI: host_rdata_q <= err_addr[15:8];
          default: host_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Controller reads; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ec_ack_q <= 1'b0;
      ec_rdata_q <= `LECC_CLK_CTRL_RST;
    end else begin
      ec_ack_q <= ec_req.valid;
      if (ec_req.valid && !ec_req.write) begin
        unique case (ec_req.offset)
          `LECC_EC_OFS_CLK: ec_rdata_q <= {30'h0000_0000, clk_sel_q};
          `LECC_EC_OFS_ERR: ec_rdata_q <= {16'h0000, err_addr};
          default: ec_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** lecc_chk.sv ***
// Purpose: port checks for lecc_regs; Assumes: one mclk domain; Notes: bound in tb_top
`timescale 1ns/100ps
`default_nettype none
module lecc_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire lecc_pkg::lecc_host_req_t host_req,
  input wire logic host_ack_q,
  input wire logic [7:0] host_rdata_q,
  input wire lecc_pkg::lecc_ec_req_t ec_req,
  input wire logic ec_ack_q,
  input wire lecc_pkg::lecc_err_evt_t err_evt,
  input wire logic link_clk_run,
  input wire lecc_pkg::lecc_clk_sel_t clk_sel_q,
  input wire logic [6:0] link_clk_mhz_q,
  input wire logic err_locked_q
);
  logic clr;
  // Write to either error address byte or word
  assign clr = (host_req.valid && host_req.write && host_req.index[7:1] == 7'h7a) ||
    (ec_req.valid && ec_req.write && ec_req.offset == 12'h3f4);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_host_ack: assert property (host_req.valid |=> host_ack_q) else $error("no host ack");
  a_ec_ack: assert property (ec_req.valid |=> ec_ack_q) else $error("no ec ack");
  a_host_pulse: assert property (!host_req.valid |=> !host_ack_q) else $error("host ack held");
  a_ec_pulse: assert property (!ec_req.valid |=> !ec_ack_q) else $error("ec ack held");
  a_sel_read: assert property (
    host_req.valid && !host_req.write && host_req.index == 8'hf8
    |=> host_rdata_q == {6'h0, $past(clk_sel_q)}) else $error("select readback");
  a_rate_map: assert property (
    link_clk_mhz_q == (7'h40 >> $past(clk_sel_q))) else $error("rate mismatch");
  a_sel_frozen: assert property (
    link_clk_run |=> $stable(clk_sel_q)) else $error("select moved while running");
  a_err_lock: assert property (
    err_evt.valid && !clr |-> ##2 err_locked_q) else $error("no lock");
  a_clear_unlock: assert property (
    clr |-> ##2 !err_locked_q) else $error("no unlock");
  a_clash_pend: assert property (
    clr && err_evt.valid ##1 !clr |-> ##2 err_locked_q) else $error("clash lost");
  c_clash: cover property (clr && err_evt.valid);
  c_run_wr: cover property (link_clk_run && ec_req.valid && ec_req.write);
  c_locked_evt: cover property (err_locked_q && err_evt.valid);
endmodule
`default_nettype wire

// *** lecc_host_model.sv ***
// Purpose: host, controller and link event model; Assumes: 1-cycle valid; Notes: idle inverted
`timescale 1ns/100ps
`default_nettype none
module lecc_host_model (
  input wire logic mclk,
  output var lecc_pkg::lecc_host_req_t host_req,
  input wire logic [7:0] host_rdata_q,
  output var lecc_pkg::lecc_ec_req_t ec_req,
  input wire logic [31:0] ec_rdata_q,
  output var lecc_pkg::lecc_err_evt_t err_evt
);
  import lecc_pkg::*;
  initial begin
    host_req = '0;
    ec_req = '0;
    err_evt = '0;
  end
  // Released lines show inverted value
  task automatic host(input logic w, input logic [7:0] i, d, output logic [7:0] r);
    @(posedge mclk) #1 host_req = {1'b1, w, i, d};
    @(posedge mclk) #1 host_req = {1'b0, ~w, ~i, ~d};
    r = host_rdata_q;
  endtask
  task automatic ec(input logic w, input logic [11:0] o, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge mclk) #1 ec_req = {1'b1, w, o, d};
    @(posedge mclk) #1 ec_req = {1'b0, ~w, ~o, ~d};
    r = ec_rdata_q;
  endtask
  task automatic evt(input logic [15:0] a);
    @(posedge mclk) #1 err_evt = {1'b1, a};
    @(posedge mclk) #1 err_evt = {1'b0, ~a};
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench; Assumes: lecc_regs on mclk; Notes: seed 71114
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lecc_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic link_clk_run = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 71114;
  lecc_host_req_t host_req;
  lecc_ec_req_t ec_req;
  lecc_err_evt_t err_evt;
  lecc_clk_sel_t clk_sel_q;
  logic host_ack_q;
  logic ec_ack_q;
  logic err_locked_q;
  logic [6:0] link_clk_mhz_q;
  logic [7:0] host_rdata_q;
  logic [7:0] hb;
  logic [31:0] ec_rdata_q;
  logic [31:0] eb;
  logic [15:0] a;
  logic [1:0] s;
  always #5 mclk = ~mclk;
  lecc_regs u_dut(.mclk, .resetn, .host_req, .host_ack_q, .host_rdata_q, .ec_req, .ec_ack_q,
    .ec_rdata_q, .err_evt, .link_clk_run, .clk_sel_q, .link_clk_mhz_q, .err_locked_q);
  lecc_host_model u_m(.mclk, .host_req, .host_rdata_q, .ec_req, .ec_rdata_q, .err_evt);
  function automatic logic [6:0] rate(input logic [1:0] v);
    return 7'h40 >> v;
  endfunction
  task automatic cmp(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic put_sel(input logic [1:0] v, input logic h);
    if (h) u_m.host(1'b1, 8'hf8, {6'h3f, v}, hb);
    else u_m.ec(1'b1, 12'h3f8, {30'($random(seed)), v}, eb);
    repeat (3) @(posedge mclk);
  endtask
  task automatic chk_sel(input logic [1:0] v);
    u_m.host(1'b0, 8'hf8, 8'h00, hb);
    cmp(host_ack_q, 1'b1);
    cmp(hb, {6'h0, v});
    cmp(link_clk_mhz_q, rate(v));
    u_m.ec(1'b0, 12'h3f8, 32'h0, eb);
    cmp(ec_ack_q, 1'b1);
    cmp(eb, {30'h0, v});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge mclk);
    chk_sel(2'h0);
    u_m.host(1'b0, 8'h30, 8'h00, hb);
    cmp(hb, 8'h00);
    for (int i = 0; i < 10; i++) begin
      s = (i < 4) ? i[1:0] : 2'($random(seed));
      put_sel(s, i[0]);
      chk_sel(s);
    end
    $display("clock select done");
    link_clk_run = 1'b1;
    put_sel(~s, 1'b0);
    chk_sel(s);
    link_clk_run = 1'b0;
    repeat (3) @(posedge mclk);
    chk_sel(~s);
    u_m.evt(16'h0000);
    repeat (2) @(posedge mclk);
    #1 cmp(err_locked_q, 1'b1);
    a = 16'($random(seed));
    u_m.evt(a);
    u_m.ec(1'b0, 12'h3f4, 32'h0, eb);
    cmp(eb, 32'h0);
    u_m.host(1'b1, 8'hf5, 8'h5a, hb);
    repeat (2) @(posedge mclk);
    #1 cmp(err_locked_q, 1'b0);
    u_m.evt(a);
    u_m.host(1'b0, 8'hf4, 8'h00, hb);
    cmp(hb, a[7:0]);
    u_m.host(1'b0, 8'hf5, 8'h00, hb);
    cmp(hb, a[15:8]);
    fork
      u_m.ec(1'b1, 12'h3f4, 32'hffff_ffff, eb);
      u_m.evt(~a);
    join
    @(posedge mclk);
    u_m.ec(1'b0, 12'h3f4, 32'h0, eb);
    cmp(eb, {16'h0, ~a});
    u_m.host(1'b1, 8'hf4, 8'ha5, hb);
    u_m.ec(1'b0, 12'h3f4, 32'h0, eb);
    cmp(eb, 32'h0);
    $display("error capture done");
    // Mid-run reset must drop a nonzero select back to zero
    put_sel(2'h3, 1'b1);
    chk_sel(2'h3);
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge mclk);
    chk_sel(2'h0);
    $display("reset rerun done");
    conclude();
  end
endmodule
bind lecc_regs lecc_chk u_chk(.mclk, .resetn, .host_req, .host_ack_q, .host_rdata_q, .ec_req,
  .ec_ack_q, .err_evt, .link_clk_run, .clk_sel_q, .link_clk_mhz_q, .err_locked_q);
`default_nettype wire
